/* shared/add_and_pkg.sv */
// Package with register offsets, field positions, opcodes and reset values of the executor.
package add_and_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int BYTE_W = 8;
  localparam int INSTR_W = 14;
  localparam int FILE_DEPTH = 128;
  localparam int FILE_AW = 7;

  localparam logic [ADDR_W-1:0] ADDR_INSTR = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_ACC = 12'h004;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h008;
  localparam logic [ADDR_W-1:0] ADDR_FILE_PTR = 12'h00C;
  localparam logic [ADDR_W-1:0] ADDR_FILE_DATA = 12'h010;
  localparam logic [ADDR_W-1:0] ADDR_COUNT = 12'h014;

  localparam int STAT_CARRY_BIT = 0;
  localparam int STAT_DIGIT_BIT = 1;
  localparam int STAT_ZERO_BIT = 2;
  localparam int STAT_BAD_BIT = 3;

  localparam int DEST_BIT = 7;
  localparam logic [4:0] OPC_ADD_LIT = 5'h1F;
  localparam logic [5:0] OPC_AND_LIT = 6'h39;
  localparam logic [5:0] OPC_ADD_REG = 6'h07;
  localparam logic [5:0] OPC_AND_REG = 6'h05;

  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic FLAG_RST = 1'b0;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [6:0] PTR_RST = 7'h00;
  localparam logic [13:0] INSTR_RST = 14'h0000;

endpackage

/* hw/alu_byte.sv */
// Byte adder and AND unit with carry, digit carry and zero outputs.
`timescale 1ns/1ps
module alu_byte
  import add_and_pkg::*;
#(
  parameter int WIDTH = BYTE_W
) (
  input wire logic [WIDTH-1:0] opnd_a,
  input wire logic [WIDTH-1:0] opnd_b,
  input wire logic do_add,
  output logic [WIDTH-1:0] result,
  output logic carry_out,
  output logic digit_out,
  output logic zero_out
);

  logic [WIDTH:0] sum_full;
  logic [4:0] sum_low;

  always_comb begin
    sum_full = {1'b0, opnd_a} + {1'b0, opnd_b};
    sum_low = {1'b0, opnd_a[3:0]} + {1'b0, opnd_b[3:0]};
    result = do_add ? sum_full[WIDTH-1:0] : (opnd_a & opnd_b);
    carry_out = sum_full[WIDTH]; // RL6
    digit_out = sum_low[4]; // RL6
    zero_out = (result == '0); // RL6
  end

endmodule

/* hw/add_and_exec.sv */
// Executor for add and and instructions with a register file, reached over APB.
//
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
// Summary of operation
// RL1: Add-literal opcode adds the literal to the accumulator, updating carry, digit carry, zero.
// RL2: And-literal opcode ANDs the literal into the accumulator, updating only zero.
// RL3: Add-register opcode adds accumulator and file register, updating carry, digit carry, zero.
// RL4: Register forms write the accumulator when destination is 0, the register when 1.
// RL5: And-register opcode ANDs accumulator and file register, updating only zero.
// RL6: Carry from bit 7, digit carry from bit 3, zero on zero result, one cycle.
module add_and_exec
  import add_and_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr
);

  typedef struct packed {
    logic [BYTE_W-1:0] acc;
    logic carry;
    logic digit_carry;
    logic zero;
    logic bad_op;
    logic [FILE_AW-1:0] ptr;
    logic [15:0] count;
    logic [INSTR_W-1:0] last_instr;
    logic [FILE_DEPTH-1:0][BYTE_W-1:0] file;
    logic [DATA_W-1:0] rdata;
    logic err;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  logic wr_en;
  logic setup;
  logic exec;
  logic [INSTR_W-1:0] instr;
  logic add_literal_op;
  logic and_literal_op;
  logic add_register_op;
  logic and_register_op;
  logic reg_form;
  logic known_op;
  logic [FILE_AW-1:0] file_idx;
  logic [BYTE_W-1:0] opnd;
  logic [BYTE_W-1:0] alu_res;
  logic alu_c;
  logic alu_dc;
  logic alu_z;
  logic mapped;

  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pwrite;
  assign exec = wr_en & (paddr == ADDR_INSTR);
  assign instr = pwdata[INSTR_W-1:0];
  assign file_idx = instr[FILE_AW-1:0];
  assign add_literal_op = (instr[13:9] == OPC_ADD_LIT); // RL1
  assign and_literal_op = (instr[13:8] == OPC_AND_LIT); // RL2
  assign add_register_op = (instr[13:8] == OPC_ADD_REG); // RL3
  assign and_register_op = (instr[13:8] == OPC_AND_REG); // RL5
  assign reg_form = add_register_op | and_register_op;
  assign known_op = add_literal_op | and_literal_op | reg_form;
  assign opnd = reg_form ? st_r.file[file_idx] : instr[BYTE_W-1:0];
  assign mapped = (paddr == ADDR_INSTR) | (paddr == ADDR_ACC) | (paddr == ADDR_STATUS) |
                  (paddr == ADDR_FILE_PTR) | (paddr == ADDR_FILE_DATA) | (paddr == ADDR_COUNT);

  alu_byte #(
    .WIDTH(BYTE_W)
  ) alu_byte_i (
    .opnd_a(st_r.acc),
    .opnd_b(opnd),
    .do_add(add_literal_op | add_register_op),
    .result(alu_res),
    .carry_out(alu_c),
    .digit_out(alu_dc),
    .zero_out(alu_z)
  );

  assign pready = psel & penable;
  assign prdata = st_r.rdata;
  assign pslverr = psel & penable & st_r.err;

  always_comb begin
    st_nxt = st_r;
    if (setup) begin
      st_nxt.err = ~mapped;
      case (paddr)
        ADDR_INSTR: st_nxt.rdata = {18'h00000, st_r.last_instr};
        ADDR_ACC: st_nxt.rdata = {24'h000000, st_r.acc};
        ADDR_STATUS: st_nxt.rdata = {28'h0000000, st_r.bad_op, st_r.zero,
                                     st_r.digit_carry, st_r.carry};
        ADDR_FILE_PTR: st_nxt.rdata = {25'h0000000, st_r.ptr};
        ADDR_FILE_DATA: st_nxt.rdata = {24'h000000, st_r.file[st_r.ptr]};
        ADDR_COUNT: st_nxt.rdata = {16'h0000, st_r.count};
        default: st_nxt.rdata = 32'h00000000;
      endcase
    end
    if (wr_en) begin
      case (paddr)
        ADDR_ACC: st_nxt.acc = pwdata[BYTE_W-1:0];
        ADDR_STATUS: begin
          st_nxt.carry = pwdata[STAT_CARRY_BIT];
          st_nxt.digit_carry = pwdata[STAT_DIGIT_BIT];
          st_nxt.zero = pwdata[STAT_ZERO_BIT];
          st_nxt.bad_op = st_r.bad_op & ~pwdata[STAT_BAD_BIT];
        end
        ADDR_FILE_PTR: st_nxt.ptr = pwdata[FILE_AW-1:0];
        ADDR_FILE_DATA: st_nxt.file[st_r.ptr] = pwdata[BYTE_W-1:0];
        default: st_nxt.err = st_r.err;
      endcase
    end
    if (exec) begin
      st_nxt.last_instr = instr;
      if (known_op) begin
        st_nxt.count = st_r.count + 16'h0001; // RL6
        st_nxt.zero = alu_z; // RL6
        if (add_literal_op | add_register_op) begin
          st_nxt.carry = alu_c; // RL1 RL3
          st_nxt.digit_carry = alu_dc; // RL1 RL3
        end
        if (reg_form && instr[DEST_BIT]) begin
          st_nxt.file[file_idx] = alu_res; // RL4
        end else begin
          st_nxt.acc = alu_res; // RL1 RL2 RL4
        end
      end else begin
        st_nxt.bad_op = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      st_r <= '0;
      st_r.acc <= ACC_RST;
      st_r.carry <= FLAG_RST;
      st_r.digit_carry <= FLAG_RST;
      st_r.zero <= FLAG_RST;
      st_r.bad_op <= FLAG_RST;
      st_r.ptr <= PTR_RST;
      st_r.count <= COUNT_RST;
      st_r.last_instr <= INSTR_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  logic [8:0] chk_sum9;
  logic [4:0] chk_sum5;
  logic [BYTE_W-1:0] chk_and;
  assign chk_sum9 = {1'b0, st_r.acc} + {1'b0, opnd};
  assign chk_sum5 = {1'b0, st_r.acc[3:0]} + {1'b0, opnd[3:0]};
  assign chk_and = st_r.acc & opnd;

  add_lit_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RL1
    exec && add_literal_op |=> st_r.acc == $past(chk_sum9[7:0]) &&
      st_r.carry == $past(chk_sum9[8]) && st_r.digit_carry == $past(chk_sum5[4]))
    else $error("Add literal gave a wrong sum or flags.");

  and_lit_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RL2
    exec && and_literal_op |=> st_r.acc == $past(chk_and) && $stable(st_r.carry) &&
      $stable(st_r.digit_carry) && st_r.zero == (st_r.acc == 8'h00))
    else $error("And literal gave a wrong result or touched carry.");

  add_reg_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RL3
    exec && add_register_op |=> st_r.carry == $past(chk_sum9[8]) &&
      st_r.digit_carry == $past(chk_sum5[4]) && st_r.zero == ($past(chk_sum9[7:0]) == 8'h00))
    else $error("Add register gave wrong flags.");

  dest_file_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RL4
    exec && reg_form && instr[DEST_BIT] |=> $stable(st_r.acc) &&
      st_r.file[$past(file_idx)] == $past(alu_res))
    else $error("Destination one did not write the file register.");

  dest_acc_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RL4
    exec && reg_form && !instr[DEST_BIT] |=> st_r.acc == $past(alu_res) &&
      st_r.file[$past(file_idx)] == $past(opnd))
    else $error("Destination zero did not write the accumulator only.");

  and_reg_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RL5
    exec && and_register_op |=> $stable(st_r.carry) && $stable(st_r.digit_carry) &&
      st_r.zero == ($past(chk_and) == 8'h00))
    else $error("And register gave wrong zero or touched carry.");

  one_cycle_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RL6
    exec && known_op |=> st_r.count == $past(st_r.count) + 16'h0001 ##1
      (st_r.acc == $past(st_r.acc) || $past(wr_en)))
    else $error("Instruction did not complete in one cycle.");

  count_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RL6
    !(exec && known_op) |=> $stable(st_r.count))
    else $error("Instruction count moved without an executed instruction.");

  zero_flag_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RL6
    exec && known_op |=> st_r.zero == ($past(add_literal_op || add_register_op) ?
      ($past(chk_sum9[7:0]) == 8'h00) : ($past(chk_and) == 8'h00)))
    else $error("Zero flag does not match the result.");

  lit_file_a: assert property (@(posedge sys_clk) disable iff (!resetn) // RL1 RL2
    exec && (add_literal_op || and_literal_op) |=> $stable(st_r.file))
    else $error("Literal instruction changed a file register.");

  bad_op_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    exec && !known_op |=> st_r.bad_op && $stable(st_r.acc) && $stable(st_r.count) &&
      $stable(st_r.carry) && $stable(st_r.digit_carry))
    else $error("Unknown opcode was executed or not flagged.");

  slverr_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    psel && !penable && !mapped ##1 psel && penable |-> pslverr && prdata == 32'h00000000)
    else $error("Unmapped access gave no error or nonzero data.");

  unmapped_wr_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    wr_en && !mapped |=> $stable(st_r.acc) && $stable(st_r.ptr) && $stable(st_r.count))
    else $error("Write to an unmapped address changed state.");

endmodule

/* verification/add_and_alu_instructions_test.sv */
// Testbench for the add and and instruction executor.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module add_and_alu_instructions_test;
  import add_and_pkg::*;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [DATA_W-1:0] prdata;
  logic pready;
  logic pslverr;
  logic [DATA_W-1:0] q;
  logic err;
  int n_mismatch = 0;
  int total_checks = 0;
  int n_exec = 0;

  add_and_exec add_and_exec_i (.sys_clk(sys_clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

  initial begin
    forever #10 sys_clk = ~sys_clk;
  end

  task stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // One APB transfer; read data and error are taken at the edge with pready high.
  task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Loads operands, executes one instruction and checks the results.
  task run(input logic [7:0] a, input logic [7:0] f, input logic [2:0] st,
    input logic [13:0] ins, input logic [7:0] ea, input logic [7:0] ef, input logic [3:0] es);
    apb(1'b1, ADDR_ACC, {24'h0, a});
    apb(1'b1, ADDR_STATUS, {28'h0, 1'b1, st});
    apb(1'b1, ADDR_FILE_PTR, {25'h0, ins[6:0]});
    apb(1'b1, ADDR_FILE_DATA, {24'h0, f});
    apb(1'b1, ADDR_INSTR, {18'h0, ins});
    if (!es[3]) n_exec++;
    apb(1'b0, ADDR_ACC, '0);
    `CHK("acc", {24'h0, ea}, q)
    apb(1'b0, ADDR_STATUS, '0);
    `CHK("status", {28'h0, es}, q)
    apb(1'b0, ADDR_FILE_DATA, '0);
    `CHK("file", {24'h0, ef}, q)
  endtask

  task t_reset();
    apb(1'b0, ADDR_ACC, '0);
    `CHK("acc_rst", 32'h0, q)
    apb(1'b0, ADDR_STATUS, '0);
    `CHK("status_rst", 32'h0, q)
    apb(1'b0, ADDR_COUNT, '0);
    `CHK("count_rst", 32'h0, q)
    $display("done t_reset");
  endtask

  task t_add_lit();
    run(8'h10, 8'h00, 3'h0, {OPC_ADD_LIT, 1'b0, 8'h15}, 8'h25, 8'h00, 4'h0);
    run(8'hF8, 8'h33, 3'h0, {OPC_ADD_LIT, 1'b1, 8'h08}, 8'h00, 8'h33, 4'h7);
    run(8'h0F, 8'h00, 3'h7, {OPC_ADD_LIT, 1'b0, 8'h70}, 8'h7F, 8'h00, 4'h0);
    $display("done t_add_lit");
  endtask

  task t_and_lit();
    run(8'hA3, 8'h11, 3'h3, {OPC_AND_LIT, 8'h5F}, 8'h03, 8'h11, 4'h3);
    run(8'hA3, 8'h11, 3'h3, {OPC_AND_LIT, 8'h5C}, 8'h00, 8'h11, 4'h7);
    $display("done t_and_lit");
  endtask

  task t_add_reg();
    run(8'h17, 8'hC2, 3'h0, {OPC_ADD_REG, 1'b0, 7'h05}, 8'hD9, 8'hC2, 4'h0);
    run(8'h0F, 8'h01, 3'h5, {OPC_ADD_REG, 1'b1, 7'h7F}, 8'h0F, 8'h10, 4'h2);
    run(8'h80, 8'h80, 3'h0, {OPC_ADD_REG, 1'b1, 7'h00}, 8'h80, 8'h00, 4'h5);
    $display("done t_add_reg");
  endtask

  task t_and_reg();
    run(8'h17, 8'hC2, 3'h3, {OPC_AND_REG, 1'b1, 7'h40}, 8'h17, 8'h02, 4'h3);
    run(8'h0F, 8'hF0, 3'h3, {OPC_AND_REG, 1'b0, 7'h01}, 8'h00, 8'hF0, 4'h7);
    $display("done t_and_reg");
  endtask

  task t_refuse();
    run(8'h55, 8'h66, 3'h0, 14'h3400, 8'h55, 8'h66, 4'h8);
    apb(1'b0, ADDR_INSTR, '0);
    `CHK("instr", 32'h00003400, q)
    `CHK("slverr_ok", 1'b0, err)
    apb(1'b1, 12'h018, 32'hFFFF_FFFF);
    `CHK("slverr_wr", 1'b1, err)
    apb(1'b0, 12'h018, '0);
    `CHK("slverr_rd", 1'b1, err)
    `CHK("unmapped_rd", 32'h0, q)
    apb(1'b0, ADDR_COUNT, '0);
    `CHK("count", 32'(n_exec), q)
    $display("done t_refuse");
  endtask

  initial begin
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    t_reset();
    t_add_lit();
    t_and_lit();
    t_add_reg();
    t_and_reg();
    t_refuse();
    stop_test();
  end

  // The tests take well under 1000 cycles; this cuts a hung handshake short.
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    stop_test();
  end
endmodule
